//--- hdl/spt_pkg.sv
// Package: register map, field positions, reset values and timing counts
package spt_pkg;
	// Register byte addresses
	localparam logic [3:0] ADDR_PROT_CTRL  = 4'h0;
	localparam logic [3:0] ADDR_PIT_CTRL   = 4'h4;
	localparam logic [3:0] ADDR_PIT_COUNT  = 4'h8;
	localparam logic [3:0] ADDR_WD_SERVICE = 4'hC;
	// Protection control fields
	localparam int WD_ENABLE_BIT   = 7;
	localparam int WD_RST_IRQ_BIT  = 6;
	localparam int WD_TIMING_LSB   = 4;
	localparam int DBF_ENABLE_BIT  = 3;
	localparam int BUS_MON_DIS_BIT = 2;
	localparam int BUS_MON_TO_LSB  = 0;
	localparam logic [7:0] PROT_CTRL_RESET = 8'hFC;
	// Periodic timer count fields
	localparam int WD_PRESCALE_BIT  = 9;
	localparam int PIT_PRESCALE_BIT = 8;
	// Periodic control fields
	localparam int PIT_LEVEL_LSB = 8;
	localparam logic [10:0] PIT_CTRL_RESET = 11'h00F;
	// Service sequence keys
	localparam logic [7:0] SERVICE_KEY_1 = 8'h55;
	localparam logic [7:0] SERVICE_KEY_2 = 8'hAA;
	// Prescaler divide ratio
	localparam logic [8:0] PRESCALE_LAST = 9'h1FF;
	// Crystal divide-by-128 ratio
	localparam logic [6:0] XTAL_DIV_LAST = 7'h7F;
	// Watchdog exponents for codes 00..11
	localparam int WD_EXP_BASE = 9;
	// Bus monitor timeouts in system clocks
	localparam logic [10:0] BM_TO_00 = 11'h400;
	localparam logic [10:0] BM_TO_01 = 11'h200;
	localparam logic [10:0] BM_TO_10 = 11'h100;
	localparam logic [10:0] BM_TO_11 = 11'h080;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- hdl/spt_top.sv
// System protection, watchdog and periodic interrupt timer block
// What this block does
// - Watchdog timing codes select 2^9,2^11,2^13,2^15 input clocks unprescaled
// - Watchdog prescale bit divides by 512 first, giving 2^18..2^24
// - Watchdog timing field resets to code 11, longest timeout
// - Watchdog input clock is crystal divided by 1 or 128 per mode pins
// - New watchdog timeout applies only after 0x55 then 0xAA service
// - Double fault monitor runs when enable bit is 1; defaults to 1
// - External bus monitor disable bit is active low enable; defaults to 1
// - Bus monitor timeout codes give 1024, 512, 256, 128 system clocks
// - Periodic control bits 15..11 read zero, writes ignored
// - Periodic level zero disables interrupt; 1..7 request that level
// - Periodic timer keeps counting while its level is zero
// - Interrupt acknowledge for periodic level returns programmed 8-bit vector
// - Periodic count register bits 15..10 read zero, writes ignored
// - Periodic prescale bit divides periodic clock by 512, else none
// - Both prescale bits reset to inverted mode pin one at reset release
// - Periodic control and count registers writable any time, unprotected
// - Count register: watchdog prescale bit 9, periodic bit 8, count 7..0
// - Periodic count of zero stops the timer; count rewritable any time
// - Watchdog timeout gives level 7 interrupt or reset per select bit
// - Protection control readable always, only first write accepted
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module spt_top
(
	// Clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        RST_N_IN,
	// Mode pins
	input  wire logic        CLOCK_MODE_PIN_ONE_IN,
	input  wire logic        XTAL_DIV128_SEL_IN,
	// Interrupt acknowledge from core
	input  wire logic        IACK_IN,
	input  wire logic [2:0]  IACK_LEVEL_IN,
	// Bus monitor activity and double fault input
	input  wire logic        BUS_CYCLE_ACTIVE_IN,
	input  wire logic        BUS_CYCLE_EXTERNAL_IN,
	input  wire logic        DOUBLE_FAULT_IN,
	// AXI4-Lite write address
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [3:0]  S_AXI_AWADDR,
	// AXI4-Lite write data
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	// AXI4-Lite write response
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	output logic [1:0]       S_AXI_BRESP,
	// AXI4-Lite read address
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	input  wire logic [3:0]  S_AXI_ARADDR,
	// AXI4-Lite read data
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	// Interrupt, reset and bus error outputs
	output logic [2:0]       IRQ_LEVEL_OUT,
	output logic             IACK_VECTOR_VALID_OUT,
	output logic [7:0]       IACK_VECTOR_OUT,
	output logic             SYSTEM_RESET_REQ_OUT,
	output logic             BUS_ERROR_OUT,
	output logic             DOUBLE_FAULT_RESET_OUT
);

	typedef enum logic [2:0]
	{
		SVC_IDLE = 3'b001,
		SVC_GOT1 = 3'b010,
		SVC_ERR  = 3'b100
	} spt_svc_t;

	typedef struct packed
	{
		logic [1:0]  mode_sync;
		logic [1:0]  div_sync;
		logic [2:0]  iack_sync;
		logic [5:0]  lvl_sync;
		logic [1:0]  bus_sync;
		logic [1:0]  ext_sync;
		logic [1:0]  dbf_sync;
		logic [1:0]  strap_cnt;
		logic [7:0]  prot;
		logic        prot_locked;
		logic [10:0] pit_ctrl;
		logic [9:0]  pit_cnt_reg;
		logic [1:0]  wd_timing_act;
		logic        wd_pre_act;
		spt_svc_t    svc;
		logic [6:0]  xdiv;
		logic        xtick;
		logic [8:0]  wd_pre;
		logic [8:0]  pit_pre;
		logic [15:0] wd_cnt;
		logic [7:0]  pit_cnt;
		logic        pit_pend;
		logic        wd_irq;
		logic [10:0] bm_cnt;
		logic        aw_got;
		logic [3:0]  aw_addr;
		logic        w_got;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [2:0]  irq;
		logic        vec_valid;
		logic [7:0]  vec;
		logic        sys_rst;
		logic        bus_err;
		logic        dbf_rst;
	} spt_state_t;

	spt_state_t st_reg;
	spt_state_t st_next;

	logic        wr_fire;
	logic [15:0] wd_limit;
	logic [10:0] bm_limit;
	logic        wd_tick;
	logic        pit_tick;
	logic [7:0]  wdat;

	always_comb
	begin
		st_next = st_reg;
		wdat = st_reg.w_data[7:0];
		st_next.mode_sync = {st_reg.mode_sync[0], CLOCK_MODE_PIN_ONE_IN};
		st_next.div_sync  = {st_reg.div_sync[0], XTAL_DIV128_SEL_IN};
		st_next.iack_sync = {st_reg.iack_sync[1:0], IACK_IN};
		st_next.lvl_sync  = {st_reg.lvl_sync[2:0], IACK_LEVEL_IN};
		st_next.bus_sync  = {st_reg.bus_sync[0], BUS_CYCLE_ACTIVE_IN};
		st_next.ext_sync  = {st_reg.ext_sync[0], BUS_CYCLE_EXTERNAL_IN};
		st_next.dbf_sync  = {st_reg.dbf_sync[0], DOUBLE_FAULT_IN};
		// Capture inverted synced mode pin once after reset release
		if (st_reg.strap_cnt != 2'h3)
			st_next.strap_cnt = st_reg.strap_cnt + 2'h1;
		if (st_reg.strap_cnt == 2'h2)
		begin
			st_next.pit_cnt_reg[9:8] = {2{~st_reg.mode_sync[1]}};
			st_next.wd_pre_act = ~st_reg.mode_sync[1];
		end
		// Acknowledge on synced request edge; expiries below win over clear
		st_next.vec_valid = 1'b0;
		if (st_reg.iack_sync[1] && !st_reg.iack_sync[2])
		begin
			if (st_reg.wd_irq && st_reg.lvl_sync[5:3] == 3'h7)
				st_next.wd_irq = 1'b0;
			else if (st_reg.pit_pend &&
				st_reg.lvl_sync[5:3] == st_reg.pit_ctrl[10:8])
			begin
				st_next.vec = st_reg.pit_ctrl[7:0];
				st_next.vec_valid = 1'b1;
				st_next.pit_pend = 1'b0;
			end
		end
		// Crystal divide by 1 or 128
		st_next.xtick = 1'b0;
		if (st_reg.div_sync[1])
		begin
			st_next.xdiv = st_reg.xdiv + 7'h01;
			st_next.xtick = (st_reg.xdiv == spt_pkg::XTAL_DIV_LAST);
		end
		else
		begin
			st_next.xdiv = 7'h00;
			st_next.xtick = 1'b1;
		end
		// Watchdog prescaler
		wd_tick = 1'b0;
		if (st_reg.xtick)
		begin
			if (st_reg.wd_pre_act)
			begin
				st_next.wd_pre = st_reg.wd_pre + 9'h001;
				wd_tick = (st_reg.wd_pre == spt_pkg::PRESCALE_LAST);
			end
			else
			begin
				wd_tick = 1'b1;
			end
		end
		wd_limit = 16'h0001 << (spt_pkg::WD_EXP_BASE +
			2 * int'(st_reg.wd_timing_act));
		if (st_reg.prot[spt_pkg::WD_ENABLE_BIT] && wd_tick)
		begin
			if (st_reg.wd_cnt == wd_limit - 16'h0001)
			begin
				st_next.wd_cnt = 16'h0000;
				if (st_reg.prot[spt_pkg::WD_RST_IRQ_BIT])
					st_next.sys_rst = 1'b1;
				else
					st_next.wd_irq = 1'b1;
			end
			else
			begin
				st_next.wd_cnt = st_reg.wd_cnt + 16'h0001;
			end
		end
		// Periodic prescaler and counter, runs regardless of level
		pit_tick = 1'b0;
		if (st_reg.xtick)
		begin
			if (st_reg.pit_cnt_reg[spt_pkg::PIT_PRESCALE_BIT])
			begin
				st_next.pit_pre = st_reg.pit_pre + 9'h001;
				pit_tick = (st_reg.pit_pre == spt_pkg::PRESCALE_LAST);
			end
			else
			begin
				pit_tick = 1'b1;
			end
		end
		if (st_reg.pit_cnt_reg[7:0] == 8'h00)
		begin
			st_next.pit_cnt = 8'h00;
		end
		else if (pit_tick)
		begin
			if (st_reg.pit_cnt <= 8'h01)
			begin
				st_next.pit_cnt = st_reg.pit_cnt_reg[7:0];
				if (st_reg.pit_ctrl[10:8] != 3'h0)
					st_next.pit_pend = 1'b1;
			end
			else
			begin
				st_next.pit_cnt = st_reg.pit_cnt - 8'h01;
			end
		end
		// Interrupt level output, watchdog interrupt at level 7
		if (st_reg.wd_irq)
			st_next.irq = 3'h7;
		else if (st_reg.pit_pend && st_reg.pit_ctrl[10:8] != 3'h0)
			st_next.irq = st_reg.pit_ctrl[10:8];
		else
			st_next.irq = 3'h0;
		// Bus monitor on external cycles
		case (st_reg.prot[1:0])
			2'b00:   bm_limit = spt_pkg::BM_TO_00;
			2'b01:   bm_limit = spt_pkg::BM_TO_01;
			2'b10:   bm_limit = spt_pkg::BM_TO_10;
			default: bm_limit = spt_pkg::BM_TO_11;
		endcase
		st_next.bus_err = 1'b0;
		if (!st_reg.prot[spt_pkg::BUS_MON_DIS_BIT] && st_reg.bus_sync[1] &&
			st_reg.ext_sync[1])
		begin
			st_next.bm_cnt = st_reg.bm_cnt + 11'h001;
			if (st_reg.bm_cnt == bm_limit - 11'h001)
			begin
				st_next.bus_err = 1'b1;
				st_next.bm_cnt = 11'h000;
			end
		end
		else
		begin
			st_next.bm_cnt = 11'h000;
		end
		st_next.dbf_rst = st_reg.prot[spt_pkg::DBF_ENABLE_BIT] &&
			st_reg.dbf_sync[1];
		// AXI write channel capture
		if (S_AXI_AWVALID && !st_reg.aw_got)
		begin
			st_next.aw_got = 1'b1;
			st_next.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !st_reg.w_got)
		begin
			st_next.w_got = 1'b1;
			st_next.w_data = S_AXI_WDATA;
			st_next.w_strb = S_AXI_WSTRB;
		end
		wr_fire = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
		if (wr_fire)
		begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = spt_pkg::RESP_OKAY;
			case (st_reg.aw_addr)
				spt_pkg::ADDR_PROT_CTRL:
				begin
					if (!st_reg.prot_locked && st_reg.w_strb[0])
					begin
						st_next.prot = wdat;
						st_next.prot_locked = 1'b1;
					end
				end
				spt_pkg::ADDR_PIT_CTRL:
				begin
					if (st_reg.w_strb[0])
						st_next.pit_ctrl[7:0] = wdat;
					if (st_reg.w_strb[1])
						st_next.pit_ctrl[10:8] = st_reg.w_data[10:8];
				end
				spt_pkg::ADDR_PIT_COUNT:
				begin
					if (st_reg.w_strb[0])
						st_next.pit_cnt_reg[7:0] = wdat;
					if (st_reg.w_strb[1])
						st_next.pit_cnt_reg[9:8] = st_reg.w_data[9:8];
				end
				spt_pkg::ADDR_WD_SERVICE:
				begin
					if (st_reg.w_strb[0])
					begin
						if (wdat == spt_pkg::SERVICE_KEY_1)
							st_next.svc = SVC_GOT1;
						else if (wdat == spt_pkg::SERVICE_KEY_2 &&
							st_reg.svc == SVC_GOT1)
						begin
							st_next.svc = SVC_IDLE;
							st_next.wd_timing_act = st_reg.prot[5:4];
							st_next.wd_pre_act =
								st_reg.pit_cnt_reg[spt_pkg::WD_PRESCALE_BIT];
							st_next.wd_cnt = 16'h0000;
							st_next.wd_pre = 9'h000;
						end
						else
							st_next.svc = SVC_ERR;
					end
				end
				default: st_next.bresp = spt_pkg::RESP_SLVERR;
			endcase
		end
		if (st_reg.bvalid && S_AXI_BREADY)
			st_next.bvalid = 1'b0;
		// AXI read channel
		if (S_AXI_ARVALID && !st_reg.rvalid)
		begin
			st_next.rvalid = 1'b1;
			st_next.rresp = spt_pkg::RESP_OKAY;
			case (S_AXI_ARADDR)
				spt_pkg::ADDR_PROT_CTRL:
					st_next.rdata = {24'h000000, st_reg.prot};
				spt_pkg::ADDR_PIT_CTRL:
					st_next.rdata = {21'h000000, st_reg.pit_ctrl};
				spt_pkg::ADDR_PIT_COUNT:
					st_next.rdata = {22'h000000, st_reg.pit_cnt_reg};
				spt_pkg::ADDR_WD_SERVICE:
					st_next.rdata = 32'h00000000;
				default:
				begin
					st_next.rdata = 32'h00000000;
					st_next.rresp = spt_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (st_reg.rvalid && S_AXI_RREADY)
		begin
			st_next.rvalid = 1'b0;
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			st_reg <= '0;
			st_reg.prot <= spt_pkg::PROT_CTRL_RESET;
			st_reg.pit_ctrl <= spt_pkg::PIT_CTRL_RESET;
			st_reg.wd_timing_act <= 2'h3;
			st_reg.svc <= SVC_IDLE;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign S_AXI_AWREADY = !st_reg.aw_got;
	assign S_AXI_WREADY = !st_reg.w_got;
	assign S_AXI_BVALID = st_reg.bvalid;
	assign S_AXI_BRESP = st_reg.bresp;
	assign S_AXI_ARREADY = !st_reg.rvalid;
	assign S_AXI_RVALID = st_reg.rvalid;
	assign S_AXI_RDATA = st_reg.rdata;
	assign S_AXI_RRESP = st_reg.rresp;
	assign IRQ_LEVEL_OUT = st_reg.irq;
	assign IACK_VECTOR_VALID_OUT = st_reg.vec_valid;
	assign IACK_VECTOR_OUT = st_reg.vec;
	assign SYSTEM_RESET_REQ_OUT = st_reg.sys_rst;
	assign BUS_ERROR_OUT = st_reg.bus_err;
	assign DOUBLE_FAULT_RESET_OUT = st_reg.dbf_rst;

endmodule
`default_nettype wire

//--- testbench/spt_props.sv
// Checker of the block's port behaviour
`timescale 1ns/100ps
`default_nettype none
module spt_props
(
	// Clock and reset
	input wire logic        CLK_IN,
	input wire logic        RST_N_IN,
	// Inputs watched
	input wire logic        IACK_IN,
	input wire logic        BUS_CYCLE_ACTIVE_IN,
	input wire logic        BUS_CYCLE_EXTERNAL_IN,
	input wire logic        DOUBLE_FAULT_IN,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_RREADY,
	// Outputs watched
	input wire logic        S_AXI_ARREADY,
	input wire logic        S_AXI_RVALID,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0]  S_AXI_RRESP,
	input wire logic        IACK_VECTOR_VALID_OUT,
	input wire logic        BUS_ERROR_OUT,
	input wire logic        DOUBLE_FAULT_RESET_OUT
);
	logic [10:0] ext_cnt;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	// Unbroken external bus cycle length
	always_ff @(posedge CLK_IN or negedge RST_N_IN)
		if (!RST_N_IN)
			ext_cnt <= 11'h000;
		else if (!(BUS_CYCLE_ACTIVE_IN && BUS_CYCLE_EXTERNAL_IN))
			ext_cnt <= 11'h000;
		else if (ext_cnt != 11'h7FF)
			ext_cnt <= ext_cnt + 11'h001;
	a_berr_after_count: assert property (
		BUS_ERROR_OUT |-> ext_cnt >= 11'h080)
		else $error("bus error before 128 external cycles");
	a_berr_one_pulse: assert property (
		BUS_ERROR_OUT |=> !BUS_ERROR_OUT)
		else $error("bus error longer than one cycle");
	a_dbf_needs_fault: assert property (
		!DOUBLE_FAULT_IN [*4] |-> !DOUBLE_FAULT_RESET_OUT)
		else $error("double fault reset without fault");
	a_vec_in_ack: assert property (
		IACK_VECTOR_VALID_OUT |-> IACK_IN && $past(IACK_IN))
		else $error("vector outside acknowledge");
	a_vec_one_pulse: assert property (
		IACK_VECTOR_VALID_OUT |=> !IACK_VECTOR_VALID_OUT)
		else $error("vector pulse too long");
	a_read_answer: assert property (
		S_AXI_ARVALID && S_AXI_ARREADY && !S_AXI_RVALID |=> S_AXI_RVALID)
		else $error("read answer late");
	a_read_one_beat: assert property (
		S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
		else $error("read answer repeated");
	a_upper_zero: assert property (
		S_AXI_RVALID && S_AXI_RRESP == 2'h0 |-> S_AXI_RDATA[31:16] == 16'h0000)
		else $error("upper read bits not zero");
endmodule
`default_nettype wire

//--- testbench/spt_cpu_model.sv
// Core model that acknowledges periodic interrupt requests
`timescale 1ns/100ps
`default_nettype none
module spt_cpu_model
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// Request and answer from the block
	input  wire logic [2:0] irq_level_in,
	input  wire logic       vec_valid_in,
	// Acknowledge to the block
	output logic            iack_out,
	output logic [2:0]      iack_level_out
);
	int gap;
	initial
	begin
		iack_out = 1'b0;
		iack_level_out = 3'h0;
		gap = 0;
		forever
		begin
			@(posedge clk_in);
			if (!rst_n_in)
				iack_out <= 1'b0;
			else if (iack_out && vec_valid_in)
			begin
				// Release, level line shows a changed value
				iack_out <= 1'b0;
				iack_level_out <= ~iack_level_out;
				gap++;
				repeat (3 + gap % 4)
					@(posedge clk_in);
			end
			else if (!iack_out && irq_level_in != 3'h0 && irq_level_in != 3'h7)
			begin
				iack_out <= 1'b1;
				iack_level_out <= irq_level_in;
			end
		end
	end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Testbench top: bus master, result monitor and scenarios
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0, rst_n = 1'b0, bus_act = 1'b0, bus_ext = 1'b0;
	logic        dfault = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0;
	logic        arv = 1'b0, rre = 1'b0, mode1 = 1'b0, div128 = 1'b0;
	logic [3:0]  awa = 4'h0, ara = 4'h0, wst = 4'hF;
	logic [31:0] wda = 32'h0000_0000, rdata;
	logic        awr, wrd, bv, arr, rv, vv, srq, berr, dfr, iack;
	logic [1:0]  bresp, rresp;
	logic [2:0]  irq, iack_lvl;
	logic [7:0]  vec, exp_vec = 8'h0F;
	logic [33:0] bq[$], rq[$];
	int          num_errors = 0, samples_checked = 0, seed = 41, n, nvec;
	spt_top spt_top_inst (.CLK_IN(clk), .RST_N_IN(rst_n),
		.CLOCK_MODE_PIN_ONE_IN(mode1), .XTAL_DIV128_SEL_IN(div128),
		.IACK_IN(iack), .IACK_LEVEL_IN(iack_lvl),
		.BUS_CYCLE_ACTIVE_IN(bus_act), .BUS_CYCLE_EXTERNAL_IN(bus_ext),
		.DOUBLE_FAULT_IN(dfault), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
		.S_AXI_WDATA(wda), .S_AXI_WSTRB(wst), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(bre), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv),
		.S_AXI_RREADY(rre), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.IRQ_LEVEL_OUT(irq), .IACK_VECTOR_VALID_OUT(vv),
		.IACK_VECTOR_OUT(vec), .SYSTEM_RESET_REQ_OUT(srq),
		.BUS_ERROR_OUT(berr), .DOUBLE_FAULT_RESET_OUT(dfr));
	spt_cpu_model spt_cpu_model_inst (.clk_in(clk), .rst_n_in(rst_n),
		.irq_level_in(irq), .vec_valid_in(vv), .iack_out(iack),
		.iack_level_out(iack_lvl));
	initial
		forever #5 clk = ~clk;
	function automatic logic [33:0] ok(input logic [31:0] d);
		return {spt_pkg::RESP_OKAY, d};
	endfunction
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: seen %h, expected %h",
				$time, seen, exp);
		end
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge clk);
		bq.push_back({r, 32'h0000_0000});
		awa <= a;
		wda <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awr)
				awv <= 1'b0;
			if (wrd)
				wv <= 1'b0;
		end while ((awv && !awr) || (wv && !wrd));
		while (!bv)
			@(posedge clk);
		bre <= 1'b0;
	endtask
	task automatic axi_rd(input logic [3:0] a, input logic [33:0] e);
		@(posedge clk);
		rq.push_back(e);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		do
			@(posedge clk);
		while (!arr);
		arv <= 1'b0;
		while (!rv)
			@(posedge clk);
		rre <= 1'b0;
	endtask
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Result monitor
	always @(posedge clk)
	begin
		if (bv && bre)
			check({bresp, 32'h0000_0000}, bq.pop_front());
		if (rv && rre)
			check({rresp, rdata}, rq.pop_front());
		if (vv)
		begin
			nvec++;
			check({26'h0, vec}, {26'h0, exp_vec});
		end
	end
	initial
	begin
		repeat (20)
			@(posedge clk);
		rst_n <= 1'b1;
		repeat (2)
			@(posedge clk);
		axi_wr(4'h2, 32'h0000_0000, spt_pkg::RESP_SLVERR);
		axi_rd(spt_pkg::ADDR_PROT_CTRL, ok(32'h0000_00FC));
		axi_rd(spt_pkg::ADDR_PIT_CTRL, ok(32'h0000_000F));
		axi_rd(spt_pkg::ADDR_PIT_COUNT, ok(32'h0000_0300));
		$display("test reset values done");
		// Timing code 00 chosen; later count register writes clear the watchdog prescale bit before service
		axi_wr(spt_pkg::ADDR_PROT_CTRL, 32'h0000_008B, spt_pkg::RESP_OKAY);
		axi_wr(spt_pkg::ADDR_PROT_CTRL, $random(seed), spt_pkg::RESP_OKAY);
		axi_rd(spt_pkg::ADDR_PROT_CTRL, ok(32'h0000_008B));
		bus_act <= 1'b1;
		bus_ext <= 1'b1;
		for (n = 0; !berr && n < 300; n++)
			@(posedge clk);
		check(34'(n >= 128 && n <= 136), 34'h1);
		bus_act <= 1'b0;
		bus_ext <= 1'b0;
		dfault <= 1'b1;
		repeat (5)
			@(posedge clk);
		check({33'h0, dfr}, 34'h1);
		dfault <= 1'b0;
		$display("test monitors done");
		exp_vec = 8'hA5;
		n = $random(seed);
		axi_wr(spt_pkg::ADDR_PIT_CTRL, {n[31:11], 11'h5A5}, spt_pkg::RESP_OKAY);
		axi_rd(spt_pkg::ADDR_PIT_CTRL, ok(32'h0000_05A5));
		axi_wr(spt_pkg::ADDR_PIT_COUNT, 32'hFFFF_FC03, spt_pkg::RESP_OKAY);
		axi_rd(spt_pkg::ADDR_PIT_COUNT, ok(32'h0000_0003));
		nvec = 0;
		repeat (200)
			@(posedge clk);
		check(34'(nvec >= 5), 34'h1);
		div128 <= 1'b1;
		repeat (20)
			@(posedge clk);
		nvec = 0;
		repeat (400)
			@(posedge clk);
		check(34'(nvec <= 2), 34'h1);
		div128 <= 1'b0;
		axi_wr(spt_pkg::ADDR_PIT_CTRL, 32'h0000_00A5, spt_pkg::RESP_OKAY);
		repeat (20)
			@(posedge clk);
		nvec = 0;
		repeat (50)
			@(posedge clk);
		check({31'h0, irq}, 34'h0);
		check(34'(nvec), 34'h0);
		$display("test periodic timer done");
		axi_wr(spt_pkg::ADDR_PIT_COUNT, 32'h0000_0000, spt_pkg::RESP_OKAY);
		axi_wr(spt_pkg::ADDR_WD_SERVICE, 32'h0000_0055, spt_pkg::RESP_OKAY);
		axi_wr(spt_pkg::ADDR_WD_SERVICE, 32'h0000_00AA, spt_pkg::RESP_OKAY);
		for (n = 0; irq !== 3'h7 && n < 2000; n++)
			@(posedge clk);
		check(34'(n >= 505 && n <= 520), 34'h1);
		check({33'h0, srq}, 34'h0);
		$display("test watchdog done");
		end_of_test();
	end
	// Watchdog against hangs
	initial
	begin
		repeat (20000)
			@(posedge clk);
		num_errors++;
		end_of_test();
	end
endmodule
bind spt_top spt_props spt_props_inst (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
	.IACK_IN(IACK_IN), .BUS_CYCLE_ACTIVE_IN(BUS_CYCLE_ACTIVE_IN),
	.BUS_CYCLE_EXTERNAL_IN(BUS_CYCLE_EXTERNAL_IN),
	.DOUBLE_FAULT_IN(DOUBLE_FAULT_IN), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_RREADY(S_AXI_RREADY), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RRESP(S_AXI_RRESP), .IACK_VECTOR_VALID_OUT(IACK_VECTOR_VALID_OUT),
	.BUS_ERROR_OUT(BUS_ERROR_OUT),
	.DOUBLE_FAULT_RESET_OUT(DOUBLE_FAULT_RESET_OUT));
`default_nettype wire
